// ---- design/neutral_overvoltage_pkg.sv ----
// Purpose: Shared constants and types of the neutral overvoltage stage.
// Assumes: Voltages in steps of 0.01 % of nominal voltage.
// Notes: Delays count 5 ms measurement updates.
package neutral_overvoltage_pkg;
  // ==========================================================
  // Scaling and timing
  localparam int unsigned UPDATE_PERIOD_MS = 5; // Measurement time base
  localparam int unsigned DELAY_STEP_MS = 5; // Delay setting step
  localparam int unsigned DIAL_STEP_MS = 10; // Time dial step, 0.01 s
  localparam int unsigned DIAL_TO_STEPS = DIAL_STEP_MS / UPDATE_PERIOD_MS;
  localparam logic [13:0] THR_MIN = 14'd100; // 1.00 %
  localparam logic [13:0] THR_MAX = 14'd9900; // 99.00 %
  localparam logic [13:0] THR_DEFAULT = 14'd2000; // 20.00 %
  localparam logic [31:0] RESET_RATIO_PCT = 32'd97; // Release level
  localparam logic [31:0] PCT_FULL = 32'd100;
  localparam logic [31:0] CALC_DIVISOR = 32'd3; // One third of the sum
  localparam logic [16:0] RATIO_MAX = 17'd125000; // 1250.00
  localparam logic [47:0] ROOT_FIRST_BIT = 48'h0010_0000_0000; // Bit 36
  localparam logic [47:0] Q16_ONE = 48'h0000_0001_0000;
  localparam logic [17:0] POWER_SAT_EXP = 18'd24; // Power saturates here
  localparam logic [5:0] ROOT_ITER = 6'd19;
  localparam logic [5:0] DIV_ITER = 6'd48;
  localparam logic [18:0] STEPS_MAX = 19'h7ffff;
  // ==========================================================
  // Enumerations
  typedef enum logic [1:0] {
    SRC_UNSELECTED = 2'b00, SRC_CALC = 2'b01, SRC_THIRD = 2'b10, SRC_FOURTH = 2'b11
  } source_select_t;
  typedef enum logic [1:0] {
    MEAS_NONE = 2'b00, MEAS_CALC = 2'b01, MEAS_THIRD = 2'b10, MEAS_FOURTH = 2'b11
  } measuring_t;
  typedef enum logic [1:0] {
    FORCE_NORMAL = 2'b00, FORCE_START = 2'b01, FORCE_TRIP = 2'b10, FORCE_BLOCKED = 2'b11
  } force_t;
  typedef enum logic {FIXED_DELAY_MODE = 1'b0, INVERSE_DELAY_MODE = 1'b1} delay_mode_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_ROOT = 3'b001, ST_RATIO = 3'b010,
    ST_POWER = 3'b011, ST_TIME = 3'b100, ST_DECIDE = 3'b101
  } state_t;
endpackage

// ---- design/neutral_overvoltage_stage.sv ----
// Purpose: Pick-up, blocking and operate timing of the neutral overvoltage stage.
// Assumes: Measurement and block inputs come from logic on clk_sys.
// Notes: One evaluation per measurement_update pulse; at most 118 cycles each.
`timescale 1ns/100ps
`default_nettype none
module neutral_overvoltage_stage
  import neutral_overvoltage_pkg::*;
#(
  parameter int GROUPS = 8
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic measurement_update, // 5 ms refresh pulse
  input wire logic signed [15:0] l1_re, // Phase voltage phasors
  input wire logic signed [15:0] l1_im,
  input wire logic signed [15:0] l2_re,
  input wire logic signed [15:0] l2_im,
  input wire logic signed [15:0] l3_re,
  input wire logic signed [15:0] l3_im,
  input wire logic [15:0] third_voltage_input,
  input wire logic [15:0] fourth_voltage_input,
  input wire logic third_residual_mode,
  input wire logic fourth_residual_mode,
  input wire logic line_to_neutral_connected,
  input wire logic [1:0] source_select,
  input wire logic stage_forcing_enable,
  input wire logic [1:0] force_status,
  input wire logic block_in,
  input wire logic [$clog2(GROUPS)-1:0] active_group,
  input wire logic [GROUPS-1:0][13:0] group_threshold,
  input wire logic [GROUPS-1:0] group_delay_mode,
  input wire logic [GROUPS-1:0][18:0] group_fixed_delay, // 5 ms steps
  input wire logic [GROUPS-1:0][12:0] group_time_dial, // 0.01 s steps
  input wire logic [GROUPS-1:0][11:0] group_multiplier, // 0.01 steps
  output logic start,
  output logic trip,
  output logic blocked,
  output logic pickup,
  output logic [1:0] measuring_now,
  output logic [16:0] ratio_now,
  output logic [18:0] expected_steps
);
  // ==========================================================
  // Helpers
  // One restoring division step: returns quotient/dividend and remainder
  function automatic logic [95:0] div_step(input logic [47:0] n, r, d);
    logic [47:0] r2;
    logic [47:0] n2;
    r2 = {r[46:0], n[47]};
    n2 = {n[46:0], 1'b0};
    if (r2 >= d) begin
      r2 = r2 - d;
      n2[0] = 1'b1;
    end
    return {n2, r2};
  endfunction
  // Piecewise linear log2 of a Q16 value above one, result Q16
  function automatic logic [21:0] log2_q16(input logic [47:0] x);
    logic [5:0] p;
    logic [47:0] n;
    p = '0;
    for (int i = 0; i < 48; i++) begin
      if (x[i]) begin
        p = 6'(i);
      end
    end
    n = x << (6'd47 - p);
    return {6'(p - 6'd16), n[46:31]};
  endfunction
  // ==========================================================
  // Evaluation state
  state_t state, next_state;
  logic [5:0] cnt, next_cnt; // Iterations left
  logic [47:0] num, next_num; // Operand / quotient
  logic [47:0] rem, next_rem; // Remainder / root
  logic [47:0] den, next_den; // Divisor / root bit
  logic [18:0] mag, next_mag; // Measured magnitude
  logic [13:0] thr, next_thr;
  logic mode, next_mode;
  logic [18:0] fix_steps, next_fix_steps;
  logic [12:0] dial, next_dial;
  logic [11:0] mult, next_mult;
  logic blk, next_blk; // Block sampled at update
  logic pick_eval, next_pick_eval; // Fresh comparison result
  logic [18:0] steps, next_steps; // Operate time in updates
  logic [18:0] elapsed, next_elapsed;
  logic start_i, next_start_i;
  logic trip_i, next_trip_i;
  logic blocked_i, next_blocked_i;
  logic next_start, next_trip, next_blocked, next_pickup;
  logic [1:0] next_measuring;
  logic [16:0] next_ratio;
  // Combinational scratch
  logic [47:0] sq_sum, root_try, pow, rsum;
  logic signed [17:0] sre, sim;
  logic signed [47:0] sre_w, sim_w; // Sums widened before squaring
  logic [33:0] expo;
  logic [34:0] ratio_pct;
  logic [95:0] ds;
  logic [1:0] src_eff;
  logic [13:0] thr_sel;
  // ==========================================================
  // Next-value logic
  // Latch group settings and inputs on each update, then walk the
  // root and divide steps; a long serial path keeps area small.
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_num = num;
    next_rem = rem;
    next_den = den;
    next_mag = mag;
    next_thr = thr;
    next_mode = mode;
    next_fix_steps = fix_steps;
    next_dial = dial;
    next_mult = mult;
    next_blk = blk;
    next_pick_eval = pick_eval;
    next_steps = steps;
    next_elapsed = elapsed;
    next_start_i = start_i;
    next_trip_i = trip_i;
    next_blocked_i = blocked_i;
    next_pickup = pickup;
    next_measuring = measuring_now;
    next_ratio = ratio_now;
    // Phasor sum of the three phases
    sre = 18'(l1_re) + 18'(l2_re) + 18'(l3_re);
    sim = 18'(l1_im) + 18'(l2_im) + 18'(l3_im);
    // Widen first so the squares never wrap at 18 bits
    sre_w = {{30{sre[17]}}, sre};
    sim_w = {{30{sim[17]}}, sim};
    sq_sum = sre_w * sre_w + sim_w * sim_w;
    root_try = rem + den;
    ds = div_step(num, rem, den);
    expo = 34'((34'(log2_q16(num)) * 34'(mult)) / 34'(PCT_FULL));
    pow = 48'({1'b1, expo[15:0]}) << expo[21:16];
    // Round to the nearest 0.01 so an exact 1.20 does not read 1.19
    ratio_pct = 35'((35'(num) * 35'(PCT_FULL) + 35'h8000) >> 16);
    rsum = 48'(mag) * 48'(PCT_FULL);
    // Static selector, not part of any group
    src_eff = MEAS_NONE;
    unique case (source_select)
      SRC_CALC: src_eff = MEAS_CALC;
      SRC_THIRD: src_eff = third_residual_mode ? MEAS_THIRD : MEAS_NONE;
      SRC_FOURTH: src_eff = fourth_residual_mode ? MEAS_FOURTH : MEAS_NONE;
      SRC_UNSELECTED: src_eff = line_to_neutral_connected ? MEAS_CALC : MEAS_NONE;
    endcase
    // Clamp the threshold into its legal range
    thr_sel = group_threshold[active_group];
    if (thr_sel < THR_MIN) begin
      thr_sel = THR_MIN;
    end else if (thr_sel > THR_MAX) begin
      thr_sel = THR_MAX;
    end
    unique case (state)
      ST_IDLE: begin
        if (measurement_update) begin
          next_thr = thr_sel;
          next_mode = group_delay_mode[active_group];
          next_fix_steps = group_fixed_delay[active_group];
          next_dial = group_time_dial[active_group];
          next_mult = group_multiplier[active_group];
          next_blk = block_in;
          next_measuring = src_eff;
          next_rem = '0;
          if (src_eff == MEAS_CALC) begin
            next_num = sq_sum;
            next_den = ROOT_FIRST_BIT;
            next_cnt = ROOT_ITER;
            next_state = ST_ROOT;
          end else begin
            // Residual inputs are already on the line-to-line scale
            next_mag = (src_eff == MEAS_THIRD) ? 19'(third_voltage_input) :
                       (src_eff == MEAS_FOURTH) ? 19'(fourth_voltage_input) : '0;
            next_num = {13'h0, next_mag, 16'h0};
            next_den = 48'(thr_sel);
            next_cnt = DIV_ITER;
            next_state = ST_RATIO;
          end
        end
      end
      ST_ROOT: begin
        // Bitwise square root of the phasor sum magnitude
        if (num >= root_try) begin
          next_num = num - root_try;
          next_rem = (rem >> 1) + den;
        end else begin
          next_rem = rem >> 1;
        end
        next_den = den >> 2;
        next_cnt = cnt - 6'd1;
        if (cnt == 6'd1) begin
          // A third of a phase-scaled sum lands on the line-to-line scale
          next_mag = 19'(next_rem / 48'(CALC_DIVISOR));
          next_num = {13'h0, next_mag, 16'h0};
          next_rem = '0;
          next_den = 48'(thr);
          next_cnt = DIV_ITER;
          next_state = ST_RATIO;
        end
      end
      ST_RATIO: begin
        next_num = ds[95:48];
        next_rem = ds[47:0];
        next_cnt = cnt - 6'd1;
        if (cnt == 6'd1) begin
          if (measuring_now == MEAS_NONE) begin
            next_pick_eval = 1'b0;
          end else if (!pickup) begin
            next_pick_eval = mag > 19'(thr);
          end else begin
            next_pick_eval = !(rsum < 48'(thr) * 48'(RESET_RATIO_PCT));
          end
          next_state = ST_POWER;
        end
      end
      ST_POWER: begin
        // num holds the Q16 ratio here
        next_ratio = (ratio_pct > 35'(RATIO_MAX)) ? RATIO_MAX : 17'(ratio_pct);
        next_steps = fix_steps;
        next_state = ST_DECIDE;
        if (mode == INVERSE_DELAY_MODE && pick_eval) begin
          if (num <= Q16_ONE) begin
            // Held in the hysteresis band: log2 would wrap, so use the longest delay, STEPS_MAX
            next_steps = STEPS_MAX;
          end else if (expo[33:16] >= POWER_SAT_EXP) begin
            next_steps = '0;
          end else if (pow <= Q16_ONE) begin
            next_steps = STEPS_MAX;
          end else begin
            next_num = 48'({dial, 16'h0}) * 48'(DIAL_TO_STEPS);
            next_rem = '0;
            next_den = pow - Q16_ONE;
            next_cnt = DIV_ITER;
            next_state = ST_TIME;
          end
        end
      end
      ST_TIME: begin
        next_num = ds[95:48];
        next_rem = ds[47:0];
        next_cnt = cnt - 6'd1;
        if (cnt == 6'd1) begin
          next_steps = (ds[95:48] > 48'(STEPS_MAX)) ? STEPS_MAX : 19'(ds[95:48]);
          next_state = ST_DECIDE;
        end
      end
      ST_DECIDE: begin
        next_pickup = pick_eval;
        next_state = ST_IDLE;
        if (!pick_eval) begin
          next_start_i = 1'b0;
          next_trip_i = 1'b0;
          next_blocked_i = 1'b0;
          next_elapsed = '0;
        end else if (!pickup) begin
          // Block state at the moment of pick-up decides the outcome
          next_blocked_i = blk;
          next_start_i = !blk;
          next_trip_i = !blk && (steps == '0);
          next_elapsed = 19'd1;
        end else if (start_i && blk) begin
          next_start_i = 1'b0;
          next_trip_i = 1'b0;
          next_blocked_i = 1'b1;
          next_elapsed = '0;
        end else if (start_i) begin
          next_trip_i = trip_i || (elapsed >= steps);
          if (elapsed != STEPS_MAX) begin
            next_elapsed = elapsed + 19'd1;
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // Forced status masks the stage's own result
    next_start = next_start_i;
    next_trip = next_trip_i;
    next_blocked = next_blocked_i;
    if (stage_forcing_enable && force_status != FORCE_NORMAL) begin
      next_start = force_status == FORCE_START;
      next_trip = force_status == FORCE_TRIP;
      next_blocked = force_status == FORCE_BLOCKED;
    end
  end
  // ==========================================================
  // State registers
  // Register only; all outputs leave from flip-flops
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= ST_IDLE;
      cnt <= '0;
      num <= '0;
      rem <= '0;
      den <= '0;
      mag <= '0;
      thr <= THR_DEFAULT;
      mode <= FIXED_DELAY_MODE;
      fix_steps <= '0;
      dial <= '0;
      mult <= '0;
      blk <= 1'b0;
      pick_eval <= 1'b0;
      steps <= '0;
      elapsed <= '0;
      start_i <= 1'b0;
      trip_i <= 1'b0;
      blocked_i <= 1'b0;
      start <= 1'b0;
      trip <= 1'b0;
      blocked <= 1'b0;
      pickup <= 1'b0;
      measuring_now <= MEAS_NONE;
      ratio_now <= '0;
      expected_steps <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      num <= next_num;
      rem <= next_rem;
      den <= next_den;
      mag <= next_mag;
      thr <= next_thr;
      mode <= next_mode;
      fix_steps <= next_fix_steps;
      dial <= next_dial;
      mult <= next_mult;
      blk <= next_blk;
      pick_eval <= next_pick_eval;
      steps <= next_steps;
      elapsed <= next_elapsed;
      start_i <= next_start_i;
      trip_i <= next_trip_i;
      blocked_i <= next_blocked_i;
      start <= next_start;
      trip <= next_trip;
      blocked <= next_blocked;
      pickup <= next_pickup;
      measuring_now <= next_measuring;
      ratio_now <= next_ratio;
      expected_steps <= next_steps;
    end
  end
  // ==========================================================
  // Checks
  a_source_gate: assert property (@(posedge clk_sys) disable iff (reset)
    state == ST_IDLE && measurement_update && source_select == SRC_THIRD &&
    !third_residual_mode |=> measuring_now == MEAS_NONE)
    else $error("third input used without residual mode");
  a_fallback_calc: assert property (@(posedge clk_sys) disable iff (reset)
    state == ST_IDLE && measurement_update && source_select == SRC_UNSELECTED &&
    line_to_neutral_connected |=> measuring_now == MEAS_CALC && state == ST_ROOT ##18
    state == ST_ROOT ##1 state == ST_RATIO)
    else $error("unselected source did not fall back to calculation");
  a_pickup_rise: assert property (@(posedge clk_sys) disable iff (reset)
    state == ST_RATIO && cnt == 6'd1 && !pickup && measuring_now != MEAS_NONE &&
    mag > 19'(thr) |=> pick_eval ##[1:50] pickup)
    else $error("pick-up missed above threshold");
  a_release_level: assert property (@(posedge clk_sys) disable iff (reset)
    state == ST_RATIO && cnt == 6'd1 && pickup && measuring_now != MEAS_NONE &&
    48'(mag) * 48'(PCT_FULL) >= 48'(thr) * 48'(RESET_RATIO_PCT) |=> pick_eval)
    else $error("pick-up released above reset level");
  a_thr_range: assert property (@(posedge clk_sys) disable iff (reset)
    thr >= THR_MIN && thr <= THR_MAX)
    else $error("threshold out of range");
  a_block_first: assert property (@(posedge clk_sys) disable iff (reset)
    state == ST_DECIDE && pick_eval && !pickup && blk |=> blocked_i && !start_i)
    else $error("start given while blocked at pick-up");
  a_zero_delay: assert property (@(posedge clk_sys) disable iff (reset)
    state == ST_DECIDE && pick_eval && !pickup && !blk && steps == '0 |=>
    start_i && trip_i)
    else $error("zero delay did not trip with start");
  a_force_trip: assert property (@(posedge clk_sys) disable iff (reset)
    stage_forcing_enable && force_status == FORCE_TRIP |=> trip && !start && !blocked)
    else $error("forced trip not shown");
  a_hold_between: assert property (@(posedge clk_sys) disable iff (reset)
    state != ST_DECIDE |=> pickup == $past(pickup))
    else $error("pick-up changed between updates");
endmodule
`default_nettype wire

// ---- tb/meas_front_end.sv ----
// Purpose: Behavioural measurement front end and block input pass-through for the stage.
// Assumes: Phase units are 0.01 % of nominal phase-to-neutral voltage.
// Notes: Balanced phasors plus an offset of three times the level on L1 alone.
`timescale 1ns/100ps
`default_nettype none
module meas_front_end (
  input wire logic fire,
  input wire logic [15:0] u0_level,
  input wire logic block_req,
  output logic measurement_update,
  output logic signed [15:0] l1_re,
  output logic signed [15:0] l1_im,
  output logic signed [15:0] l2_re,
  output logic signed [15:0] l2_im,
  output logic signed [15:0] l3_re,
  output logic signed [15:0] l3_im,
  output logic [15:0] third_voltage_input,
  output logic [15:0] fourth_voltage_input,
  output logic block_in
);
  // ==========================================================
  // Measurement set
  // The balanced part sums to zero, so the phase sum is exactly 3 x level
  always_comb begin
    measurement_update = fire;
    l1_re = 16'sh2710 + signed'(u0_level * 16'h3);
    l1_im = 16'sh0;
    l2_re = -16'sh1388;
    l2_im = -16'sh21d4;
    l3_re = -16'sh1388;
    l3_im = 16'sh21d4;
    third_voltage_input = u0_level;
    // Half level keeps the fourth channel distinguishable from the third
    fourth_voltage_input = u0_level >> 1;
    // Block level is set well before the pulse that samples it
    block_in = block_req;
  end
endmodule
`default_nettype wire

// ---- tb/neutral_overvoltage_stage_tb.sv ----
// Purpose: Self-checking bench for the neutral overvoltage stage.
// Assumes: Outputs settle within 118 cycles of an update pulse.
// Notes: Each update waits 130 cycles, so pulses never overlap an evaluation.
`timescale 1ns/100ps
`default_nettype none
module neutral_overvoltage_stage_tb;
  import neutral_overvoltage_pkg::*;
  // ==========================================================
  // Signals
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic fire = 1'b0;
  logic [15:0] level = 16'h0;
  logic block_req = 1'b0;
  logic upd_p, blk, m3 = 1'b1, m4 = 1'b1, ln = 1'b1, fen = 1'b0;
  logic signed [15:0] l1r, l1i, l2r, l2i, l3r, l3i;
  logic [15:0] v3, v4;
  logic [1:0] src = 2'b01;
  logic [1:0] fst = 2'b00;
  logic [2:0] grp = 3'h0;
  logic [7:0][13:0] thr = {8{14'h7d0}};
  logic [7:0] dmode = 8'h0;
  logic [7:0][18:0] fdel = {8{19'h2}};
  logic [7:0][12:0] dial = {8{13'h64}};
  logic [7:0][11:0] mult = {8{12'h64}};
  logic start, trip, blocked, pickup;
  logic [1:0] meas;
  logic [16:0] ratio;
  logic [18:0] steps;
  int error_cnt = 0;
  int n_tests = 0;
  always #2.5 clk_sys = ~clk_sys;
  // ==========================================================
  // Partner and design
  meas_front_end u_meas_front_end (.fire(fire), .u0_level(level), .block_req(block_req),
    .measurement_update(upd_p), .l1_re(l1r), .l1_im(l1i), .l2_re(l2r), .l2_im(l2i),
    .l3_re(l3r), .l3_im(l3i), .third_voltage_input(v3), .fourth_voltage_input(v4),
    .block_in(blk));
  neutral_overvoltage_stage u_neutral_overvoltage_stage (.clk_sys(clk_sys), .reset(reset),
    .measurement_update(upd_p), .l1_re(l1r), .l1_im(l1i), .l2_re(l2r), .l2_im(l2i),
    .l3_re(l3r), .l3_im(l3i), .third_voltage_input(v3), .fourth_voltage_input(v4),
    .third_residual_mode(m3), .fourth_residual_mode(m4), .line_to_neutral_connected(ln),
    .source_select(src), .stage_forcing_enable(fen), .force_status(fst), .block_in(blk),
    .active_group(grp), .group_threshold(thr), .group_delay_mode(dmode),
    .group_fixed_delay(fdel), .group_time_dial(dial), .group_multiplier(mult),
    .start(start), .trip(trip), .blocked(blocked), .pickup(pickup), .measuring_now(meas),
    .ratio_now(ratio), .expected_steps(steps));
  // ==========================================================
  // Helpers
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // One measurement set; the wait covers the longest evaluation
  task automatic upd(input logic [15:0] lvl);
    @(negedge clk_sys);
    level = lvl;
    fire = 1'b1;
    @(negedge clk_sys);
    fire = 1'b0;
    repeat (130) @(negedge clk_sys);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  // Source choice for every selector code, with and without residual mode
  task automatic t_source;
    logic [4:0] tab [7] = '{5'b00_1_01, 5'b00_0_00, 5'b01_1_01, 5'b10_1_10, 5'b10_0_00,
      5'b11_1_11, 5'b11_1_00};
    for (int i = 0; i < 7; i++) begin
      src = tab[i][4:3];
      ln = tab[i][2];
      m3 = (i != 4);
      m4 = (i != 6);
      upd(16'h0);
      check("measuring_now", meas, {30'h0, tab[i][1:0]});
    end
    src = 2'b01;
    ln = 1'b1;
    m3 = 1'b1;
    m4 = 1'b1;
  endtask
  // Calculated source: pick-up edge, 97 % release, fixed delay of 2 updates
  task automatic t_hysteresis;
    upd(16'h7d0);
    check("pickup at threshold", pickup, 0);
    upd(16'h960);
    check("start trip blocked", {start, trip, blocked}, 3'b100);
    check("ratio", ratio, 17'h78);
    check("steps", steps, 19'h2);
    upd(16'h79e);
    check("held pickup", {pickup, trip}, 2'b10);
    upd(16'h794);
    check("trip after delay", {start, trip}, 2'b11);
    upd(16'h793);
    check("release", {pickup, start, trip}, 3'b000);
  endtask
  // Group 1: zero delay, clamped low threshold, block at and after pick-up
  task automatic t_block_group;
    thr[1] = 14'h32;
    fdel[1] = 19'h0;
    grp = 3'h1;
    block_req = 1'b1;
    upd(16'h65);
    check("blocked pickup", {start, trip, blocked}, 3'b001);
    block_req = 1'b0;
    // A blocked pick-up stays blocked until the pick-up drops
    upd(16'h0);
    check("blocked cleared", {pickup, blocked}, 2'b00);
    upd(16'h64);
    check("clamped threshold", pickup, 0);
    upd(16'h65);
    check("instant trip", {start, trip, blocked}, 3'b110);
    block_req = 1'b1;
    upd(16'h65);
    check("block after start", {start, blocked}, 2'b01);
    block_req = 1'b0;
    upd(16'h0);
    grp = 3'h0;
  endtask
  // Third input with inverse delay: ratio 2, exponent 1, dial 1 s
  task automatic t_inverse;
    src = 2'b10;
    dmode[0] = 1'b1;
    upd(16'hfa0);
    check("inverse start", start, 1);
    check("inverse steps", (steps >= 19'hc6) && (steps <= 19'hca), 1);
    upd(16'h0);
    dmode[0] = 1'b0;
    src = 2'b01;
  endtask
  // Forced status per code, then forcing disabled
  task automatic t_force;
    for (int f = 0; f < 4; f++) begin
      @(negedge clk_sys);
      fen = 1'b1;
      fst = f[1:0];
      repeat (3) @(negedge clk_sys);
      check("forced", {start, trip, blocked}, 3'(4'b1000 >> f));
    end
    fen = 1'b0;
    repeat (3) @(negedge clk_sys);
    check("forcing off", {start, trip, blocked}, 3'b000);
    fst = 2'b00;
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (5) @(negedge clk_sys);
    reset = 1'b0;
    check("reset outputs", {start, trip, blocked, pickup, meas}, 6'h0);
    t_source();
    t_hysteresis();
    t_block_group();
    t_inverse();
    t_force();
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    report_and_stop();
  end
endmodule
`default_nettype wire
